/* mmpbp_adapter.sv */
// How it works
// - Transfers happen only during phase two.
// - Processor flags cycles carrying real transfers.
// - Processor drives read or write direction.
// - Port selected from address state alone.
// - Two low address bits pick the register.
// - Respond only when every chip select active.
// - Reads without valid address are ignored.
// - Enabled control edges pull request low.
// - Request held until software services it.
// - Reset clears registers; software programs later.
// - Sixteen programmable pins, four control lines.
// - Halt floats processor address and direction.
// - Bus available acknowledges floated address.
// - Three-state control floats address and direction.
// - Processor drives data only when enabled.
// - Reset restarts processor and all interfaces.
// - Separate non-maskable interrupt input exists.
// - Bus clock at most 1 MHz.
`timescale 1ns/1ps
`default_nettype none
module mmpbp_adapter #(
  parameter int CS0_BIT  = mmpbp_pkg::CS0_BIT_DEF,
  parameter int CS1_BIT  = mmpbp_pkg::CS1_BIT_DEF,
  parameter int CS2N_BIT = mmpbp_pkg::CS2N_BIT_DEF
) (
  input  wire logic                        clk_i,       // System clock.
  input  wire logic                        srst_i,      // Synchronous reset.
  mmpbp_bus_if.dev                         bus,         // System bus.
  input  wire logic [mmpbp_pkg::PORT_W-1:0] port_a_i,   // Side A pins in.
  output logic      [mmpbp_pkg::PORT_W-1:0] port_a_o,   // Side A pins out.
  output logic      [mmpbp_pkg::PORT_W-1:0] port_a_oe_o, // Side A drive enable.
  input  wire logic [mmpbp_pkg::PORT_W-1:0] port_b_i,   // Side B pins in.
  output logic      [mmpbp_pkg::PORT_W-1:0] port_b_o,   // Side B pins out.
  output logic      [mmpbp_pkg::PORT_W-1:0] port_b_oe_o, // Side B drive enable.
  input  wire logic [1:0]                  ctl1_i,      // First control line per side.
  input  wire logic [1:0]                  ctl2_i       // Second control line per side.
);
  import mmpbp_pkg::*;

  localparam int SW = 2 * PORT_W + 4;

  // Per-side output, direction and control registers.
  logic [PORT_W-1:0] or_q   [NUM_SIDES];
  logic [PORT_W-1:0] or_d   [NUM_SIDES];
  logic [PORT_W-1:0] ddr_q  [NUM_SIDES];
  logic [PORT_W-1:0] ddr_d  [NUM_SIDES];
  logic [CR_W-1:0]   cr_q   [NUM_SIDES];
  logic [CR_W-1:0]   cr_d   [NUM_SIDES];
  logic [PORT_W-1:0] pin_s  [NUM_SIDES];
  // Interrupt flags, edge history and request state, one bit per side.
  logic [1:0]        fl1_q, fl1_d;
  logic [1:0]        fl2_q, fl2_d;
  logic [1:0]        c1_prev_q, c2_prev_q;
  logic [1:0]        irq_q, irq_d;
  logic [1:0]        c1_s, c2_s;
  logic [SW-1:0]     sync_q;
  // Access captured in phase two and the read-data drive.
  logic              phi2_q;
  logic              acc_q, acc_d;
  logic              rw_q, rw_d;
  logic              commit, sel;
  logic [1:0]        rs_q, rs_d;
  logic [DATA_W-1:0] wd_q, wd_d;
  logic [DATA_W-1:0] rdv;
  logic [DATA_W-1:0] rdo_q, rdo_d;
  logic              rdoe_q, rdoe_d;

  // Pins and control lines come from outside and are synchronised.
  mmpbp_sync #(.W(SW)) u_pin_sync (
    .clk_i  (clk_i),
    .srst_i (srst_i),
    .d_i    ({ctl2_i, ctl1_i, port_b_i, port_a_i}),
    .q_o    (sync_q)
  );

  assign pin_s[0] = sync_q[PORT_W-1:0];
  assign pin_s[1] = sync_q[2*PORT_W-1:PORT_W];
  assign c1_s     = sync_q[2*PORT_W+1:2*PORT_W];
  assign c2_s     = sync_q[2*PORT_W+3:2*PORT_W+2];

  // Returns true when a line moved in its programmed direction.
  function automatic logic active_edge(input logic now, input logic prev, input logic rise);
    active_edge = rise ? (now & ~prev) : (~now & prev);
  endfunction

  // Register read value for a given select, with no side effect.
  function automatic logic [DATA_W-1:0] read_value(input logic [1:0] rs);
    logic s;
    s = rs[RS_SIDE_BIT];
    if (rs[RS_CTRL_BIT]) begin
      read_value = {fl1_q[s], fl2_q[s], cr_q[s]};
    end else if (cr_q[s][CR_DSEL]) begin
      read_value = (ddr_q[s] & or_q[s]) | (~ddr_q[s] & pin_s[s]);
    end else begin
      read_value = ddr_q[s];
    end
  endfunction

  // Bus decode: chip selects from address bits only, selects from the low bits.
  always_comb begin
    sel = bus.addr[CS0_BIT] & bus.addr[CS1_BIT] & ~bus.addr[CS2N_BIT];
    rdv = read_value(bus.addr[1:0]);
    // Drive data only in phase two of a valid, selected read.
    rdoe_d = sel & bus.valid_address_flag & bus.transfer_direction
             & bus.phase_two_clock;
    rdo_d  = rdoe_d ? rdv : rdo_q;
    // Load the access details while phase two is high; hold them while it is low.
    acc_d = acc_q;
    rw_d  = rw_q;
    rs_d  = rs_q;
    wd_d  = wd_q;
    if (bus.phase_two_clock) begin
      acc_d = sel & bus.valid_address_flag;
      rw_d  = bus.transfer_direction;
      rs_d  = bus.addr[1:0];
      wd_d  = bus.data_bus;
    end
    // Commit once, in the clock after phase two is seen to fall.
    commit = acc_q & phi2_q & ~bus.phase_two_clock;
  end

  // Register writes, flag updates and interrupt requests per side.
  always_comb begin
    logic s;
    logic clr;
    clr = 1'b0;
    // Every access of one cycle targets the side named by the select.
    s = rs_q[RS_SIDE_BIT];
    for (int i = 0; i < NUM_SIDES; i++) begin
      or_d[i]  = or_q[i];
      ddr_d[i] = ddr_q[i];
      cr_d[i]  = cr_q[i];
      clr      = commit && rw_q && !rs_q[RS_CTRL_BIT] && (s == i[0])
                 && cr_q[i][CR_DSEL];
      // A new edge wins over a clearing read in the same cycle.
      fl1_d[i] = active_edge(c1_s[i], c1_prev_q[i], cr_q[i][CR_C1_RISE])
                 | (fl1_q[i] & ~clr);
      fl2_d[i] = active_edge(c2_s[i], c2_prev_q[i], cr_q[i][CR_C2_RISE])
                 | (fl2_q[i] & ~clr);
      irq_d[i] = (fl1_d[i] & cr_q[i][CR_C1_IE]) | (fl2_d[i] & cr_q[i][CR_C2_IE]);
    end
    // A committed write lands in the register that the select names.
    if (commit && !rw_q) begin
      if (rs_q[RS_CTRL_BIT]) begin
        cr_d[s] = wd_q[CR_W-1:0];
      end else if (cr_q[s][CR_DSEL]) begin
        or_d[s] = wd_q;
      end else begin
        ddr_d[s] = wd_q;
      end
    end
  end

  // State registers; reset leaves every pin an input, every interrupt off.
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      for (int i = 0; i < NUM_SIDES; i++) begin
        or_q[i]  <= OR_RST;
        ddr_q[i] <= DDR_RST;
        cr_q[i]  <= CR_RST;
      end
      fl1_q     <= '0;
      fl2_q     <= '0;
      c1_prev_q <= '0;
      c2_prev_q <= '0;
      irq_q     <= '0;
      phi2_q    <= 1'b0;
      acc_q     <= 1'b0;
      rw_q      <= 1'b1;
      rs_q      <= '0;
      wd_q      <= '0;
      rdo_q     <= '0;
      rdoe_q    <= 1'b0;
    end else begin
      for (int i = 0; i < NUM_SIDES; i++) begin
        or_q[i]  <= or_d[i];
        ddr_q[i] <= ddr_d[i];
        cr_q[i]  <= cr_d[i];
      end
      fl1_q     <= fl1_d;
      fl2_q     <= fl2_d;
      c1_prev_q <= c1_s;
      c2_prev_q <= c2_s;
      irq_q     <= irq_d;
      phi2_q    <= bus.phase_two_clock;
      acc_q     <= acc_d;
      rw_q      <= rw_d;
      rs_q      <= rs_d;
      wd_q      <= wd_d;
      rdo_q     <= rdo_d;
      rdoe_q    <= rdoe_d;
    end
  end

  // Outputs straight from flops; pin enables follow data direction.
  assign port_a_o              = or_q[0];
  assign port_a_oe_o           = ddr_q[0];
  assign port_b_o              = or_q[1];
  assign port_b_oe_o           = ddr_q[1];
  assign bus.rd_data           = rdo_q;
  assign bus.rd_data_oe        = rdoe_q;
  assign bus.port_a_int_req_oe = irq_q[0];
  assign bus.port_b_int_req_oe = irq_q[1];
endmodule
`default_nettype wire

/* mmpbp_pkg.sv */
package mmpbp_pkg;

  // Bus widths and port geometry.
  localparam int ADDR_W    = 16;
  localparam int DATA_W    = 8;
  localparam int PORT_W    = 8;
  localparam int NUM_SIDES = 2;

  // Machine cycle timing: the bus clock runs at 1 MHz at most.
  localparam int CLK_PERIOD_NS  = 4;
  localparam int BUS_CYCLE_NS   = 1000;
  localparam int BUS_CYCLE_CLKS = (BUS_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Register select decoding: bit 0 picks control, bit 1 picks side B.
  localparam int RS_CTRL_BIT = 0;
  localparam int RS_SIDE_BIT = 1;

  // Control register field positions.
  localparam int CR_W       = 6;
  localparam int CR_C1_IE   = 0;
  localparam int CR_C1_RISE = 1;
  localparam int CR_DSEL    = 2;
  localparam int CR_C2_IE   = 3;
  localparam int CR_C2_RISE = 4;
  localparam int ST_C2_FLAG = 6;
  localparam int ST_C1_FLAG = 7;

  // Reset values: all lines input, all interrupts disabled.
  localparam logic [CR_W-1:0]   CR_RST  = 6'h00;
  localparam logic [PORT_W-1:0] OR_RST  = 8'h00;
  localparam logic [PORT_W-1:0] DDR_RST = 8'h00;

  // Default address bits wired to the chip selects.
  localparam int CS0_BIT_DEF  = 13;
  localparam int CS1_BIT_DEF  = 2;
  localparam int CS2N_BIT_DEF = 14;

  // Level of an undriven data bus (pulled up).
  localparam logic [DATA_W-1:0] BUS_IDLE_DATA = 8'hff;

  // Processor bus cycle kinds.
  typedef enum logic [1:0] {
    BS_IDLE = 2'b00,
    BS_XFER = 2'b01,
    BS_HALT = 2'b10
  } mmpbp_bus_e;

endpackage

/* mmpbp_bus_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface mmpbp_bus_if;
  import mmpbp_pkg::*;

  logic [ADDR_W-1:0] addr;              // Address from the processor.
  logic              addr_oe;           // Address and direction driven.
  logic              transfer_direction; // High for read.
  logic              valid_address_flag; // Real transfer this cycle.
  logic              phase_two_clock;   // Transfer enable phase.
  logic [DATA_W-1:0] wr_data;           // Processor data out.
  logic              wr_data_oe;        // Processor drives data.
  logic [DATA_W-1:0] rd_data;           // Adapter data out.
  logic              rd_data_oe;        // Adapter drives data.
  logic              port_a_int_req_oe; // Side A pulls request low.
  logic              port_b_int_req_oe; // Side B pulls request low.
  logic [DATA_W-1:0] data_bus;          // Resolved data wire.
  logic              irq_n;             // Resolved wired-OR request.

  // Resolve the shared wires from the drive enables.
  assign data_bus = rd_data_oe ? rd_data : (wr_data_oe ? wr_data : BUS_IDLE_DATA);
  assign irq_n    = ~(port_a_int_req_oe | port_b_int_req_oe);

  modport host (
    output addr, addr_oe, transfer_direction, valid_address_flag, phase_two_clock,
    output wr_data, wr_data_oe,
    input  data_bus, irq_n
  );

  modport dev (
    input  addr, addr_oe, transfer_direction, valid_address_flag, phase_two_clock,
    input  data_bus,
    output rd_data, rd_data_oe, port_a_int_req_oe, port_b_int_req_oe
  );
endinterface
`default_nettype wire

/* mmpbp_sync.sv */
`timescale 1ns/1ps
`default_nettype none
module mmpbp_sync #(
  parameter int W = 1
) (
  input  wire logic         clk_i,  // System clock.
  input  wire logic         srst_i, // Synchronous reset.
  input  wire logic [W-1:0] d_i,    // Asynchronous input.
  output logic      [W-1:0] q_o     // Synchronised output.
);
  logic [W-1:0] meta_q;

  // Two flops; only the second stage is visible.
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      meta_q <= '0;
      q_o    <= '0;
    end else begin
      meta_q <= d_i;
      q_o    <= meta_q;
    end
  end
endmodule
`default_nettype wire

/* mmpbp_host.sv */
`timescale 1ns/1ps
`default_nettype none
module mmpbp_host #(
  parameter int CYCLE_CLKS = mmpbp_pkg::BUS_CYCLE_CLKS
) (
  input  wire logic                        clk_i,                 // System clock.
  input  wire logic                        srst_i,                // Synchronous reset.
  mmpbp_bus_if.host                        bus,                   // System bus.
  input  wire logic                        cmd_valid_i,           // Request, held to done.
  input  wire logic                        cmd_write_i,           // High for write.
  input  wire logic [mmpbp_pkg::ADDR_W-1:0] cmd_addr_i,           // Target address.
  input  wire logic [mmpbp_pkg::DATA_W-1:0] cmd_wdata_i,          // Write data.
  output logic                             cmd_done_o,            // Transfer finished.
  output logic      [mmpbp_pkg::DATA_W-1:0] cmd_rdata_o,          // Read data.
  input  wire logic                        halt_i,                // Halt request.
  input  wire logic                        three_state_control_i, // Float address.
  output logic                             bus_available_o,       // Bus floated by halt.
  input  wire logic                        nonmaskable_int_i,     // Pin, asynchronous.
  output logic                             nmi_o,                 // One pulse per rise.
  output logic                             irq_o                  // Maskable request.
);
  import mmpbp_pkg::*;

  localparam int CW   = $clog2(CYCLE_CLKS);
  localparam int HALF = CYCLE_CLKS / 2;

  mmpbp_bus_e        st_q, st_d;
  logic [CW-1:0]     cnt_q, cnt_d;
  logic              last;
  logic              phi2_q, phi2_d, vma_q, vma_d, oe_q, oe_d, rw_q, rw_d;
  logic              dwoe_q, dwoe_d, done_d, ba_d, nmi_s, nmi_prev_q;
  logic [ADDR_W-1:0] addr_q, addr_d;
  logic [DATA_W-1:0] wd_q, wd_d, rd_d;

  mmpbp_sync #(.W(1)) u_nmi_sync (
    .clk_i  (clk_i),
    .srst_i (srst_i),
    .d_i    (nonmaskable_int_i),
    .q_o    (nmi_s)
  );

  // Free-running machine cycle; phase two is the second half.
  always_comb begin
    last   = (cnt_q == CW'(CYCLE_CLKS - 1));
    cnt_d  = last ? '0 : cnt_q + 1'b1;
    phi2_d = (cnt_d >= CW'(HALF));
    st_d   = st_q;
    addr_d = addr_q;
    rw_d   = rw_q;
    wd_d   = wd_q;
    if (last) begin
      if (halt_i) begin
        st_d = BS_HALT;
      end else if (cmd_valid_i && st_q != BS_XFER) begin
        st_d   = BS_XFER;
        addr_d = cmd_addr_i;
        rw_d   = ~cmd_write_i;
        wd_d   = cmd_wdata_i;
      end else begin
        st_d = BS_IDLE;
      end
    end
    vma_d  = (st_d == BS_XFER);
    oe_d   = (st_d != BS_HALT) && !three_state_control_i;
    ba_d   = (st_d == BS_HALT);
    dwoe_d = vma_d && !rw_d && phi2_d;
    done_d = last && (st_q == BS_XFER);
    rd_d   = (done_d && rw_q) ? bus.data_bus : cmd_rdata_o;
  end

  // Register the bus state; reset restarts from an idle cycle.
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      st_q            <= BS_IDLE;
      cnt_q           <= '0;
      phi2_q          <= 1'b0;
      vma_q           <= 1'b0;
      oe_q            <= 1'b1;
      rw_q            <= 1'b1;
      dwoe_q          <= 1'b0;
      addr_q          <= '0;
      wd_q            <= '0;
      cmd_done_o      <= 1'b0;
      cmd_rdata_o     <= '0;
      bus_available_o <= 1'b0;
      nmi_prev_q      <= 1'b0;
      nmi_o           <= 1'b0;
      irq_o           <= 1'b0;
    end else begin
      st_q            <= st_d;
      cnt_q           <= cnt_d;
      phi2_q          <= phi2_d;
      vma_q           <= vma_d;
      oe_q            <= oe_d;
      rw_q            <= rw_d;
      dwoe_q          <= dwoe_d;
      addr_q          <= addr_d;
      wd_q            <= wd_d;
      cmd_done_o      <= done_d;
      cmd_rdata_o     <= rd_d;
      bus_available_o <= ba_d;
      nmi_prev_q      <= nmi_s;
      nmi_o           <= nmi_s & ~nmi_prev_q;
      irq_o           <= ~bus.irq_n;
    end
  end

  assign bus.addr               = addr_q;
  assign bus.addr_oe            = oe_q;
  assign bus.transfer_direction = rw_q;
  assign bus.valid_address_flag = vma_q;
  assign bus.phase_two_clock    = phi2_q;
  assign bus.wr_data            = wd_q;
  assign bus.wr_data_oe         = dwoe_q;
endmodule
`default_nettype wire

/* mmpbp_properties.sv */
`timescale 1ns/1ps
`default_nettype none
module mmpbp_properties #(
  parameter int CS0_BIT  = mmpbp_pkg::CS0_BIT_DEF,
  parameter int CS1_BIT  = mmpbp_pkg::CS1_BIT_DEF,
  parameter int CS2N_BIT = mmpbp_pkg::CS2N_BIT_DEF
) (
  input wire logic                         clk_i,              // System clock.
  input wire logic                         srst_i,             // Synchronous reset.
  input wire logic [mmpbp_pkg::ADDR_W-1:0] addr,               // Bus address.
  input wire logic                         addr_oe,            // Address driven.
  input wire logic                         transfer_direction, // High for read.
  input wire logic                         valid_address_flag, // Real transfer.
  input wire logic                         phase_two_clock,    // Transfer phase.
  input wire logic                         wr_data_oe,         // Host drives data.
  input wire logic                         rd_data_oe,         // Adapter drives data.
  input wire logic                         port_a_int_req_oe   // Side A request.
);
  import mmpbp_pkg::*;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);

  // A read cycle that hits the adapter, and the end of a transfer phase.
  sequence s_sel_read;
    valid_address_flag && transfer_direction && addr[CS0_BIT] && addr[CS1_BIT] && !addr[CS2N_BIT];
  endsequence
  sequence s_phase2_end;
    $fell(phase_two_clock);
  endsequence

  // The adapter drives the data bus only for selected, valid reads in phase two.
  property p_rd_vma;
    rd_data_oe |-> $past(valid_address_flag) && $past(transfer_direction);
  endproperty
  a_rd_vma: assert property (p_rd_vma) else $error("read drive without valid address");
  property p_rd_phase;
    rd_data_oe |-> $past(phase_two_clock);
  endproperty
  a_rd_phase: assert property (p_rd_phase) else $error("read drive outside phase two");
  property p_rd_sel;
    rd_data_oe |-> $past(addr[CS0_BIT] && addr[CS1_BIT] && !addr[CS2N_BIT]);
  endproperty
  a_rd_sel: assert property (p_rd_sel) else $error("read drive while not selected");
  property p_rd_start;
    ($rose(phase_two_clock) ##0 s_sel_read) |=> rd_data_oe;
  endproperty
  a_rd_start: assert property (p_rd_start) else $error("selected read not answered");
  property p_rd_release;
    s_phase2_end |=> !rd_data_oe;
  endproperty
  a_rd_release: assert property (p_rd_release) else $error("read drive held too long");

  // The host drives data only in phase two of a write, never against the adapter.
  property p_no_clash;
    !(rd_data_oe && wr_data_oe);
  endproperty
  a_no_clash: assert property (p_no_clash) else $error("both ends drive the data bus");
  property p_wr_phase;
    wr_data_oe |-> phase_two_clock && !transfer_direction && valid_address_flag;
  endproperty
  a_wr_phase: assert property (p_wr_phase) else $error("write drive outside phase two");

  // Address and direction stay put for the whole transfer cycle.
  property p_addr_stable;
    valid_address_flag && $past(valid_address_flag) |-> $stable(addr) && $stable(transfer_direction) && addr_oe;
  endproperty
  a_addr_stable: assert property (p_addr_stable) else $error("address moved in a cycle");

  // A pending request drops only just after a bus transfer has ended.
  property p_irq_hold;
    $fell(port_a_int_req_oe) |-> $past(phase_two_clock, 2) || $past(phase_two_clock, 3);
  endproperty
  a_irq_hold: assert property (p_irq_hold) else $error("request dropped without service");
endmodule
`default_nettype wire

/* mmpbp_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module mmpbp_bench;
  import mmpbp_pkg::*;

  logic        clk_i, srst_i, cmd_valid, cmd_write, cmd_done, halt, three_state_control, ba, nmi_in, nmi, irq;
  logic [15:0] cmd_addr;
  logic [7:0]  cmd_wdata, cmd_rdata, pa_i, pa_o, pa_oe, pb_i, pb_o, pb_oe;
  logic [1:0]  ctl1, ctl2;
  logic [15:0] bad [3] = '{16'h0004, 16'h6004, 16'h2000};
  int          err_total = 0;
  int          compares = 0;
  int          pulses;
  time         t0;

  // The two ends face each other across one bus instance.
  mmpbp_bus_if bus ();
  mmpbp_host #(.CYCLE_CLKS(8)) mmpbp_host_i (.clk_i(clk_i), .srst_i(srst_i), .bus(bus),
    .cmd_valid_i(cmd_valid), .cmd_write_i(cmd_write), .cmd_addr_i(cmd_addr),
    .cmd_wdata_i(cmd_wdata), .cmd_done_o(cmd_done), .cmd_rdata_o(cmd_rdata), .halt_i(halt),
    .three_state_control_i(three_state_control), .bus_available_o(ba), .nonmaskable_int_i(nmi_in),
    .nmi_o(nmi), .irq_o(irq));
  mmpbp_adapter mmpbp_adapter_i (.clk_i(clk_i), .srst_i(srst_i), .bus(bus), .port_a_i(pa_i),
    .port_a_o(pa_o), .port_a_oe_o(pa_oe), .port_b_i(pb_i), .port_b_o(pb_o),
    .port_b_oe_o(pb_oe), .ctl1_i(ctl1), .ctl2_i(ctl2));
  mmpbp_properties mmpbp_properties_i (.clk_i(clk_i), .srst_i(srst_i), .addr(bus.addr),
    .addr_oe(bus.addr_oe), .transfer_direction(bus.transfer_direction),
    .valid_address_flag(bus.valid_address_flag), .phase_two_clock(bus.phase_two_clock),
    .wr_data_oe(bus.wr_data_oe), .rd_data_oe(bus.rd_data_oe),
    .port_a_int_req_oe(bus.port_a_int_req_oe));

  // The clock toggles every 2 ns.
  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end

  // Counts one comparison and reports a mismatch at once.
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One bus command, held until the host reports it done.
  task automatic xfer(input logic w, input logic [15:0] a, input logic [7:0] d);
    int n;
    @(negedge clk_i);
    cmd_valid = 1'b1;
    cmd_write = w;
    cmd_addr = a;
    cmd_wdata = d;
    n = 0;
    while (cmd_done !== 1'b1 && n < 200) begin
      @(negedge clk_i);
      n++;
    end
    cmd_valid = 1'b0;
    if (n >= 200) err_total++;
  endtask

  // A write lands in the adapter one clock after the host reports it done.
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    xfer(1'b1, a, d);
    @(negedge clk_i);
  endtask

  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    xfer(1'b0, a, 8'h00);
    chk(cmd_rdata, e);
  endtask

  // Waits a bounded time for the request line to reach a level.
  task automatic wait_irq(input logic e);
    int n;
    n = 0;
    while (irq !== e && n < 30) begin
      @(negedge clk_i);
      n++;
    end
    chk({7'h00, irq}, {7'h00, e});
  endtask

  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // Cuts a hang short well after the tests should have ended.
  initial begin
    repeat (20000) @(posedge clk_i);
    err_total++;
    end_of_test();
  end

  // Main sequence of tests.
  initial begin
    {srst_i, cmd_valid, cmd_write, halt, three_state_control, nmi_in} = 6'b100000;
    {cmd_addr, cmd_wdata, ctl1, ctl2} = '0;
    pa_i = 8'h33;
    pb_i = 8'ha5;
    repeat (8) @(negedge clk_i);
    srst_i = 1'b0;
    rd(16'h2005, 8'h00);
    rd(16'h2004, 8'h00);
    chk(pa_oe, 8'h00);
    $display("test reset finished");
    wr(16'h2004, 8'hff);
    wr(16'h2005, 8'h04);
    wr(16'h2004, 8'h5a);
    chk(pa_oe, 8'hff);
    chk(pa_o, 8'h5a);
    rd(16'h2004, 8'h5a);
    wr(16'h2006, 8'h0f);
    wr(16'h2007, 8'h04);
    wr(16'h2006, 8'h3c);
    rd(16'h2006, 8'hac);
    chk(pb_oe, 8'h0f);
    chk(pb_o, 8'h3c);
    $display("test ports finished");
    for (int i = 0; i < 3; i++) begin
      wr(bad[i], 8'h00);
      rd(bad[i], BUS_IDLE_DATA);
    end
    rd(16'h2004, 8'h5a);
    $display("test selects finished");
    wr(16'h2005, 8'h07);
    rd(16'h2004, 8'h5a);
    ctl1[0] = 1'b1;
    wait_irq(1'b1);
    repeat (24) @(negedge clk_i);
    chk({7'h00, irq}, 8'h01);
    rd(16'h2005, 8'h87);
    chk({7'h00, irq}, 8'h01);
    rd(16'h2004, 8'h5a);
    wait_irq(1'b0);
    wr(16'h2005, 8'h05);
    ctl1[0] = 1'b0;
    wait_irq(1'b1);
    rd(16'h2005, 8'h85);
    rd(16'h2004, 8'h5a);
    wait_irq(1'b0);
    wr(16'h2007, 8'h14);
    ctl2[1] = 1'b1;
    repeat (12) @(negedge clk_i);
    chk({7'h00, irq}, 8'h00);
    rd(16'h2007, 8'h54);
    rd(16'h2006, 8'hac);
    rd(16'h2007, 8'h14);
    wr(16'h2007, 8'hff);
    rd(16'h2007, 8'h3f);
    $display("test interrupts finished");
    @(negedge clk_i);
    halt = 1'b1;
    t0 = $time;
    fork
      begin
        repeat (40) @(negedge clk_i);
        chk({7'h00, ba}, 8'h01);
        chk({7'h00, bus.addr_oe}, 8'h00);
        halt = 1'b0;
      end
      begin
        wr(16'h2004, 8'h11);
        t0 = $time - t0;
      end
    join
    chk({7'h00, t0 > 160}, 8'h01);
    chk(pa_o, 8'h11);
    @(negedge clk_i);
    three_state_control = 1'b1;
    repeat (2) @(negedge clk_i);
    chk({7'h00, bus.addr_oe}, 8'h00);
    three_state_control = 1'b0;
    $display("test bus release finished");
    nmi_in = 1'b1;
    pulses = 0;
    repeat (12) begin
      @(negedge clk_i);
      if (nmi === 1'b1) pulses++;
    end
    chk(pulses[7:0], 8'h01);
    nmi_in = 1'b0;
    $display("test nonmaskable finished");
    end_of_test();
  end
endmodule
`default_nettype wire
